//--- hw/timer_flags_defs.svh
// Offsets, field positions, reset values and codes of the timer flag block
`ifndef TIMER_FLAGS_DEFS_SVH
`define TIMER_FLAGS_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFF_EVENT_FLAGS 8'h00
`define OFF_INT_MASKS 8'h04
`define OFF_ACC_CONTROL 8'h08
`define OFF_EDGE_CONTROL 8'h0C
`define OFF_COMPARE_BASE 8'h10
`define OFF_COMPARE_2 8'h14
`define OFF_COMPARE_3 8'h18
`define OFF_COMPARE_4 8'h1C
`define OFF_SHARED_REG 8'h20
`define OFF_MAIN_COUNT 8'h24
`define OFF_ACC_COUNT 8'h28
`define ADDR_WORD_LO 2
`define ADDR_WORD_HI 3
`define COMPARE_COUNT 4

// ----------------------------------------------------------------------
// Event flag word and matching enable positions
// ----------------------------------------------------------------------
`define FLG_SHARED 15
`define FLG_CMP_LO 11
`define FLG_CAP_LO 8
`define FLG_OVF 7
`define FLG_ACC_OVF 5
`define FLG_ACC_IN 4
`define FLAG_IMPL_MASK 16'hFFB0
`define MASK_WRITABLE 16'hFFB7
`define PRESC_LO 0
`define PRESC_HI 2

// ----------------------------------------------------------------------
// Accumulator control fields
// ----------------------------------------------------------------------
`define ACC_PIN_STATE 15
`define ACC_EXT_STATE 14
`define ACC_EN 6
`define ACC_MODE 5
`define ACC_EDGE 4
`define ACC_SHARED_SEL 2
`define ACC_CLK_LO 0
`define ACC_CLK_HI 1
`define ACC_WRITABLE 16'h0077
`define EDGE_WRITABLE 16'h00FF

// ----------------------------------------------------------------------
// Reset values and counter constants
// ----------------------------------------------------------------------
`define ZERO16 16'h0000
`define ONES16 16'hFFFF
`define ZERO8 8'h00
`define ONES8 8'hFF
`define COMPARE_RESET 16'hFFFF
`define PRESC_BASE_SHIFT 2
`define DIV_WIDTH 9
`define DIV_ZERO 9'h000
`define DIV_ALL 9'h1FF

`endif

//--- hw/timer_flags_pkg.sv
// Types shared by the timer flag block and its helpers
package timer_flags_pkg;
  // Capture edge selection
  typedef enum logic [1:0] {EDGE_OFF = 2'h0, EDGE_RISE = 2'h1, EDGE_FALL = 2'h2,
    EDGE_ANY = 2'h3} edge_cfg_t;
  // Gated accumulator clock source
  typedef enum logic [1:0] {ACLK_DIV512 = 2'h0, ACLK_COUNTER = 2'h1, ACLK_OVERFLOW = 2'h2,
    ACLK_EXTERNAL = 2'h3} acc_clk_t;
  // Main counter prescale select, seven taps then external clock
  typedef logic [2:0] presc_code_t;
endpackage

//--- hw/pin_edge_detect.sv
// Edge detector for a synchronous input pin with selectable edge
`timescale 1ns/100ps
module pin_edge_detect
  import timer_flags_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  input wire timer_flags_pkg::edge_cfg_t edge_cfg,
  output logic hit
);
  // Pin level one clock ago
  logic pin_last;

  // ----------------------------------------------------------------------
  // History register
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_last <= 1'b0;
    else
      pin_last <= pin;
  end

  // ----------------------------------------------------------------------
  // Edge qualification
  // ----------------------------------------------------------------------
  always_comb
  begin
    unique case (edge_cfg)
      EDGE_OFF: hit = 1'b0;           // Disabled channel
      EDGE_RISE: hit = pin & ~pin_last;
      EDGE_FALL: hit = ~pin & pin_last;
      EDGE_ANY: hit = pin ^ pin_last;
    endcase
  end
endmodule // pin_edge_detect

//--- hw/counter_prescaler.sv
// System clock divider giving the main counter tick and a divide-by-512 tick
`timescale 1ns/100ps
`include "timer_flags_defs.svh"
module counter_prescaler
  import timer_flags_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire timer_flags_pkg::presc_code_t counter_prescale_select,
  input wire logic ext_clock_rise,
  output logic counter_tick,
  output logic div512_tick
);
  // Free-running divider shared by all taps
  logic [`DIV_WIDTH-1:0] divider;

  // ----------------------------------------------------------------------
  // Divider chain
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      divider <= `DIV_ZERO;
    else
      divider <= divider + 1'b1;
  end

  // ----------------------------------------------------------------------
  // Tap selection: code k gives divide by 2^(k+2), top code external
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic [`DIV_WIDTH-1:0] tap_mask;
    tap_mask = `DIV_ZERO;
    // Low k+2 bits all ones marks the last cycle of each period
    tap_mask = `DIV_WIDTH'((`DIV_WIDTH'(1) << (counter_prescale_select
      + `PRESC_BASE_SHIFT)) - 1);
    if (counter_prescale_select == presc_code_t'(`DIV_ALL))
      counter_tick = ext_clock_rise;
    else
      counter_tick = ((divider & tap_mask) == tap_mask);
    div512_tick = (divider == `DIV_ALL);
  end
endmodule // counter_prescaler

//--- hw/timer_prescale_event_flags.sv
// Timer event flags, interrupt masks, prescaler and pulse accumulator with APB access
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/100ps
`include "timer_flags_defs.svh"
module timer_prescale_event_flags
  import timer_flags_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] capture_pins,
  input wire logic shared_channel_pin,
  input wire logic accumulator_input_pin,
  input wire logic ext_clock_pin,
  output logic timer_irq
);
  import timer_flags_pkg::*;

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [15:0] timer_event_flags;          // Sticky event flags
  logic [15:0] timer_interrupt_masks;      // Enables plus prescale select
  logic [15:0] accumulator_control;        // Writable accumulator fields
  logic [15:0] edge_control;               // Capture edge pairs, 4 channels
  logic [15:0] compare_value [`COMPARE_COUNT]; // Compare registers 1..4
  logic [15:0] shared_channel_register;    // Compare 5 or capture 4 value
  logic [15:0] main_free_counter;          // Free-running main counter
  logic [7:0] accumulator_counter;         // Pulse accumulator counter
  logic gate_last;                         // Gate level one clock ago

  // ----------------------------------------------------------------------
  // Decoded fields
  // ----------------------------------------------------------------------
  presc_code_t counter_prescale_select;
  logic shared_channel_select;             // High: capture 4, low: compare 5
  logic acc_enable;
  logic acc_gated_mode;
  logic acc_edge;
  acc_clk_t acc_clk_sel;
  assign counter_prescale_select = timer_interrupt_masks[`PRESC_HI:`PRESC_LO];
  assign shared_channel_select = accumulator_control[`ACC_SHARED_SEL];
  assign acc_enable = accumulator_control[`ACC_EN];
  assign acc_gated_mode = accumulator_control[`ACC_MODE];
  assign acc_edge = accumulator_control[`ACC_EDGE];
  assign acc_clk_sel = acc_clk_t'(accumulator_control[`ACC_CLK_HI:`ACC_CLK_LO]);

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic bus_write;                         // Write completes this edge
  logic [15:0] write_half;                 // Low half of write data
  assign bus_write = psel & penable & pready & pwrite;
  assign write_half = pwdata[15:0];

  // Byte offset of a word address, computed once per use
  function automatic logic [7:0] word_offset(input logic [7:0] addr);
    word_offset = {addr[7:`ADDR_WORD_LO], 2'b00};
  endfunction

  // Main counter value after its next advance
  function automatic logic [15:0] advance16(input logic [15:0] value);
    advance16 = 16'(value + 1'b1);
  endfunction

  // Compare hit against the value the counter is about to take
  function automatic logic counter_hits(input logic [15:0] next_cnt,
                                        input logic [15:0] target);
    counter_hits = (next_cnt == target);
  endfunction

  // Write to a given register this edge
  function automatic logic writes_to(input logic [7:0] off);
    writes_to = bus_write && (word_offset(paddr) == off);
  endfunction

  // ----------------------------------------------------------------------
  // Helpers: prescaler and pin edge detectors
  // ----------------------------------------------------------------------
  logic counter_tick;                      // Main counter advances
  logic div512_tick;                       // System clock divided by 512
  logic ext_clock_rise;                    // External clock pin rose
  logic [3:0] capture_hit;                 // Edges on capture 1..3 and shared
  logic acc_pin_event;                     // Active edge on accumulator pin
  logic [3:0] capture_level;

  assign capture_level = {shared_channel_pin, capture_pins};

  counter_prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .counter_prescale_select(counter_prescale_select),
    .ext_clock_rise(ext_clock_rise),
    .counter_tick(counter_tick),
    .div512_tick(div512_tick)
  );

  pin_edge_detect u_ext_clock (
    .pclk(pclk),
    .presetn(presetn),
    .pin(ext_clock_pin),
    .edge_cfg(EDGE_RISE),
    .hit(ext_clock_rise)
  );

  // Event counting edge: low selects falling, high selects rising
  pin_edge_detect u_acc_pin (
    .pclk(pclk),
    .presetn(presetn),
    .pin(accumulator_input_pin),
    .edge_cfg(acc_edge ? EDGE_RISE : EDGE_FALL),
    .hit(acc_pin_event)
  );

  // One detector per capture channel, the fourth being the shared pin
  for (genvar ch = 0; ch < 4; ch++)
  begin : g_capture
    pin_edge_detect u_cap (
      .pclk(pclk),
      .presetn(presetn),
      .pin(capture_level[ch]),
      .edge_cfg(edge_cfg_t'(edge_control[2*ch+1 -: 2])),
      .hit(capture_hit[ch])
    );
  end

  // ----------------------------------------------------------------------
  // Main counter and its events
  // ----------------------------------------------------------------------
  logic [15:0] next_main_count;
  logic counter_wrap;
  assign next_main_count = advance16(main_free_counter);
  assign counter_wrap = counter_tick && (main_free_counter == `ONES16);

  // Counter runs from reset; software may preset it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      main_free_counter <= `ZERO16;
    else if (writes_to(`OFF_MAIN_COUNT))
      main_free_counter <= write_half;
    else if (counter_tick)
      main_free_counter <= next_main_count;
  end

  // ----------------------------------------------------------------------
  // Pulse accumulator
  // ----------------------------------------------------------------------
  logic acc_gate_open;                     // Gate level that allows counting
  logic acc_clock_event;                   // Selected gated-mode clock
  logic acc_step;                          // Counter advances this edge
  logic acc_gate_end;                      // Gated period just finished
  logic acc_wrap;

  // Zero on the pin inhibits when edge bit is low, one when it is high
  assign acc_gate_open = accumulator_input_pin ^ acc_edge;

  // Gated-mode clock source selection
  always_comb
  begin
    unique case (acc_clk_sel)
      ACLK_DIV512: acc_clock_event = div512_tick;
      ACLK_COUNTER: acc_clock_event = counter_tick;
      ACLK_OVERFLOW: acc_clock_event = counter_wrap;
      ACLK_EXTERNAL: acc_clock_event = ext_clock_rise;
    endcase
  end

  assign acc_step = acc_enable && (acc_gated_mode ? (acc_gate_open && acc_clock_event)
                                                  : acc_pin_event);
  assign acc_gate_end = acc_enable && acc_gated_mode && gate_last && !acc_gate_open;
  assign acc_wrap = acc_step && (accumulator_counter == `ONES8);

  // Gate history, kept only in gated mode so a mode switch gives no false end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gate_last <= 1'b0;
    else
      gate_last <= acc_gate_open && acc_enable && acc_gated_mode;
  end

  // Accumulator count; a software write wins over a step
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      accumulator_counter <= `ZERO8;
    else if (writes_to(`OFF_ACC_COUNT))
      accumulator_counter <= pwdata[7:0];
    else if (acc_step)
      accumulator_counter <= 8'(accumulator_counter + 1'b1);
  end

  // ----------------------------------------------------------------------
  // Event collection into the flag layout
  // ----------------------------------------------------------------------
  logic [15:0] flag_set;                   // Events arriving this edge
  logic [15:0] flag_clear;                 // Write-one-to-clear request

  always_comb
  begin
    flag_set = `ZERO16;
    // Compare 5 on a counter match, or capture 4 on its pin edge
    if (shared_channel_select)
      flag_set[`FLG_SHARED] = capture_hit[3];
    else
      flag_set[`FLG_SHARED] = counter_tick &&
        counter_hits(next_main_count, shared_channel_register);
    for (int n = 0; n < `COMPARE_COUNT; n++)
      flag_set[`FLG_CMP_LO + n] = counter_tick &&
        counter_hits(next_main_count, compare_value[n]);
    for (int n = 0; n < 3; n++)
      flag_set[`FLG_CAP_LO + n] = capture_hit[n];
    flag_set[`FLG_OVF] = counter_wrap;
    flag_set[`FLG_ACC_OVF] = acc_wrap;
    // Pin edge in event mode, end of gate in gated mode
    flag_set[`FLG_ACC_IN] = acc_gated_mode ? acc_gate_end
                                           : (acc_enable && acc_pin_event);
  end

  assign flag_clear = (bus_write && (word_offset(paddr) == `OFF_EVENT_FLAGS)) ? write_half
                                                                              : `ZERO16;

  // Sticky flags; a new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer_event_flags <= `ZERO16;
    else
      timer_event_flags <= ((timer_event_flags & ~flag_clear) | flag_set)
                           & `FLAG_IMPL_MASK;
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  // Interrupt enables share the flag bit positions
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer_interrupt_masks <= `ZERO16;
    else if (writes_to(`OFF_INT_MASKS))
      timer_interrupt_masks <= write_half & `MASK_WRITABLE;
  end

  // Accumulator control, pin state bits are live and not stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      accumulator_control <= `ZERO16;
    else if (writes_to(`OFF_ACC_CONTROL))
      accumulator_control <= write_half & `ACC_WRITABLE;
  end

  // Capture edge configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      edge_control <= `ZERO16;
    else if (writes_to(`OFF_EDGE_CONTROL))
      edge_control <= write_half & `EDGE_WRITABLE;
  end

  // Compare registers, one word each after the base
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int n = 0; n < `COMPARE_COUNT; n++)
        compare_value[n] <= `COMPARE_RESET;
    end
    else
    begin
      for (int n = 0; n < `COMPARE_COUNT; n++)
        if (writes_to(8'(`OFF_COMPARE_BASE + 4 * n)))
          compare_value[n] <= write_half;
    end
  end

  // Shared channel value; capture latching lives outside this block
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      shared_channel_register <= `COMPARE_RESET;
    else if (writes_to(`OFF_SHARED_REG))
      shared_channel_register <= write_half;
  end

  // ----------------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------------
  // Registered, so it follows a flag by one clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer_irq <= 1'b0;
    else
      timer_irq <= |(timer_event_flags & timer_interrupt_masks & `FLAG_IMPL_MASK);
  end

  // ----------------------------------------------------------------------
  // APB read mux and handshake
  // ----------------------------------------------------------------------
  logic [15:0] read_value;                 // Register selected by paddr
  logic read_hit;                          // Address is mapped

  always_comb
  begin
    read_value = `ZERO16;
    read_hit = 1'b1;
    unique case (word_offset(paddr))
      `OFF_EVENT_FLAGS: read_value = timer_event_flags;
      `OFF_INT_MASKS: read_value = timer_interrupt_masks;
      `OFF_ACC_CONTROL:
      begin
        read_value = accumulator_control;
        read_value[`ACC_PIN_STATE] = accumulator_input_pin;
        read_value[`ACC_EXT_STATE] = ext_clock_pin;
      end
      `OFF_EDGE_CONTROL: read_value = edge_control;
      `OFF_COMPARE_BASE: read_value = compare_value[0];
      `OFF_COMPARE_2: read_value = compare_value[1];
      `OFF_COMPARE_3: read_value = compare_value[2];
      `OFF_COMPARE_4: read_value = compare_value[3];
      `OFF_SHARED_REG: read_value = shared_channel_register;
      `OFF_MAIN_COUNT: read_value = main_free_counter;
      `OFF_ACC_COUNT: read_value = {`ZERO8, accumulator_counter};
      default: read_hit = 1'b0;            // Unmapped offsets answer with an error
    endcase
  end

  // No wait state: data is captured in setup, ready rises in access.
  // This keeps every bus output straight from a flop without adding a cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= psel & ~penable;
  end

  // Error flag for unmapped addresses, valid with ready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else
      pslverr <= psel & ~penable & ~read_hit;
  end

  // Read data sampled in the setup cycle; upper half always zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel & ~penable & ~pwrite)
      prdata <= {16'h0000, read_value};
  end
endmodule // timer_prescale_event_flags

//--- test/timer_flags_properties.sv
// Port checker for the timer event flag block
`timescale 1ns/100ps
`include "timer_flags_defs.svh"
module timer_flags_properties
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer_irq
);
  // ------------------------------------------
  // Shadow state from completed bus transfers
  // ------------------------------------------
  logic [15:0] mask_sh; // Enables as software wrote them
  logic [15:0] last_flags; // Flags seen at the last read
  logic last_ok; // No flag write since that read
  wire xfer = psel && penable && pready; // Access edge
  wire flg_hit = {paddr[7:2], 2'b00} == `OFF_EVENT_FLAGS;
  wire flg_rd = xfer && !pwrite && !pslverr && flg_hit;
  // Track mask writes and flag reads; a flag write voids stickiness
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask_sh <= 16'h0000;
      last_flags <= 16'h0000;
      last_ok <= 1'b0;
    end
    else if (xfer && pwrite && {paddr[7:2], 2'b00} == `OFF_INT_MASKS)
      mask_sh <= pwdata[15:0] & `MASK_WRITABLE;
    else if (xfer && pwrite && flg_hit)
      last_ok <= 1'b0;
    else if (flg_rd)
    begin
      last_flags <= prdata[15:0];
      last_ok <= 1'b1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not one cycle after setup");
  a_unmapped_error: assert property (psel && !penable && paddr > 8'h2B |=> pslverr)
    else $error("unmapped word not refused");
  a_upper_zero: assert property (xfer && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_unused_bits: assert property (flg_rd |-> (prdata[15:0] & ~`FLAG_IMPL_MASK) == 16'h0000)
    else $error("unused flag bit set");
  a_irq_follows_flags: assert property
    (flg_rd |-> timer_irq == |(prdata[15:0] & mask_sh & `FLAG_IMPL_MASK))
    else $error("interrupt disagrees with flags and enables");
  a_irq_quiet_mask: assert property (((mask_sh & `FLAG_IMPL_MASK) == 16'h0000) [*2] |-> !timer_irq)
    else $error("interrupt with every enable clear");
  a_flags_sticky: assert property
    (flg_rd && last_ok |-> (prdata[15:0] & last_flags) == last_flags)
    else $error("flag dropped without software clear");
  a_acc_eight_bits: assert property
    (xfer && !pwrite && paddr == `OFF_ACC_COUNT |-> prdata[15:8] == 8'h00)
    else $error("accumulator wider than eight bits");
  a_rdata_held: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved without a read");
  cover property (flg_rd && timer_irq);
  cover property (flg_rd && prdata[15]);
  cover property (xfer && pslverr);
endmodule // timer_flags_properties

bind timer_prescale_event_flags timer_flags_properties u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_irq(timer_irq));

//--- test/test_timer_prescale_event_flags.sv
// Self-checking testbench for the timer event flag block
`timescale 1ns/100ps
`include "timer_flags_defs.svh"
module test_timer_prescale_event_flags;
  typedef struct packed {logic err; logic [31:0] mask; logic [31:0] data;} note_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, timer_irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] capture_pins, pins;
  logic shared_channel_pin, accumulator_input_pin, ext_clock_pin;
  logic [15:0] lfsr_state, v0; // Random source and counter snapshot
  note_t exp_q[$], n; // Expected results, oldest first
  int bad_count, total_checks, cycles;
  timer_prescale_event_flags DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_pins(capture_pins),
    .shared_channel_pin(shared_channel_pin), .accumulator_input_pin(accumulator_input_pin),
    .ext_clock_pin(ext_clock_pin), .timer_irq(timer_irq));
  // ------------------------------------------
  // Clock, timeout, bus helpers
  // ------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (exp_q.size() != 0)
      bad_count++;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Hang guard; the whole run needs a few thousand cycles
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 12000)
    begin
      bad_count++;
      results();
    end
  end
  // Note the expected answer, then one transfer; select stays up for back-to-back use
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [15:0] m, input logic [15:0] e, input logic er);
    exp_q.push_back('{er, {16'hFFFF, m}, {16'h0000, e}});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 16'h0000, 16'h0000, 1'b0);
  endtask
  task automatic rdx(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    apb(1'b0, a, 32'h00000000, m, e, 1'b0);
  endtask
  task automatic idle(input int n);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask
  // Compare every answer against the oldest note
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
    begin
      n = exp_q.pop_front();
      check(prdata & n.mask, n.data & n.mask);
      check({31'h0, pslverr}, {31'h0, n.err});
    end
  end
  // ------------------------------------------
  // Scenarios
  // ------------------------------------------
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    capture_pins = 3'h0;
    shared_channel_pin = 1'b0;
    accumulator_input_pin = 1'b0;
    ext_clock_pin = 1'b0;
    lfsr_state = 16'h0062;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdx(`OFF_EVENT_FLAGS, 16'hFFFF, 16'h0000);
    rdx(`OFF_COMPARE_BASE, 16'hFFFF, 16'hFFFF);
    apb(1'b0, 8'h30, 32'h00000000, 16'hFFFF, 16'h0000, 1'b1);
    // Random capture edges; channel 1 on any edge, shared channel on falling edge
    wr(`OFF_EDGE_CONTROL, 32'h00000097);
    wr(`OFF_ACC_CONTROL, 32'h00000004);
    wr(`OFF_INT_MASKS, 32'h00000100);
    idle(1);
    lfsr_state = lfsr(lfsr_state);
    pins = lfsr_state[2:0] | 3'h1;
    capture_pins <= pins;
    shared_channel_pin <= 1'b1;
    idle(3);
    rdx(`OFF_EVENT_FLAGS, 16'h8700, {5'h00, pins, 8'h00});
    idle(1);
    check({31'h0, timer_irq}, 32'h00000001);
    wr(`OFF_EVENT_FLAGS, 32'h00000100);
    capture_pins <= 3'h0;
    shared_channel_pin <= 1'b0;
    idle(3);
    rdx(`OFF_EVENT_FLAGS, 16'h8700, {5'h10, pins, 8'h00});
    wr(`OFF_EVENT_FLAGS, 32'h00000100);
    rdx(`OFF_EVENT_FLAGS, 16'h8700, {5'h10, pins & 3'h6, 8'h00});
    idle(2);
    check({31'h0, timer_irq}, 32'h00000000);
    // Compare matches on all four channels and the shared channel
    wr(`OFF_EVENT_FLAGS, 32'h0000FFFF);
    wr(`OFF_ACC_CONTROL, 32'h00000000);
    for (int i = 0; i < 5; i++)
      wr(`OFF_COMPARE_BASE + 8'(4 * i), 32'h00000040 + 32'(i));
    wr(`OFF_MAIN_COUNT, 32'h00000030);
    rdx(`OFF_EVENT_FLAGS, 16'hF800, 16'h0000);
    idle(100);
    rdx(`OFF_EVENT_FLAGS, 16'hF800, 16'hF800);
    // Counter wrap
    wr(`OFF_MAIN_COUNT, 32'h0000FFFC);
    rdx(`OFF_EVENT_FLAGS, 16'h0080, 16'h0000);
    idle(40);
    rdx(`OFF_EVENT_FLAGS, 16'h0080, 16'h0080);
    // Event counting across the accumulator wrap
    wr(`OFF_ACC_COUNT, 32'h000000FE);
    wr(`OFF_ACC_CONTROL, 32'h00000050);
    wr(`OFF_EVENT_FLAGS, 32'h00000030);
    repeat (2)
    begin
      accumulator_input_pin <= 1'b1;
      idle(2);
      accumulator_input_pin <= 1'b0;
      idle(2);
    end
    rdx(`OFF_ACC_COUNT, 16'h00FF, 16'h0000);
    rdx(`OFF_EVENT_FLAGS, 16'h0030, 16'h0030);
    // Gated accumulation: flag only once the gate closes
    wr(`OFF_ACC_CONTROL, 32'h00000061);
    wr(`OFF_EVENT_FLAGS, 32'h00000010);
    idle(1);
    accumulator_input_pin <= 1'b1;
    idle(20);
    rdx(`OFF_EVENT_FLAGS, 16'h0010, 16'h0000);
    idle(1);
    accumulator_input_pin <= 1'b0;
    idle(3);
    rdx(`OFF_EVENT_FLAGS, 16'h0010, 16'h0010);
    // Each divider prescale code: reads spaced four ticks apart; external clock code last, reads three edges apart
    for (int k = 0; k < 8; k++)
    begin
      wr(`OFF_INT_MASKS, 32'(k));
      rdx(`OFF_MAIN_COUNT, 16'h0000, 16'h0000);
      v0 = rd[15:0];
      if (k < 7)
        idle((16 << k) - 2);
      else
        repeat (3)
        begin
          ext_clock_pin <= 1'b1;
          idle(2);
          ext_clock_pin <= 1'b0;
          idle(2);
        end
      rdx(`OFF_MAIN_COUNT, 16'hFFFF, v0 + ((k < 7) ? 16'h0004 : 16'h0003));
    end
    idle(2);
    results();
  end
endmodule // test_timer_prescale_event_flags
